// File: mxb_bus_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module mxb_bus_ctrl #(
  parameter logic [31:0] WINDOW_BASE = 32'h6000_0000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic memCyc,
  input wire logic memStb,
  input wire logic memWe,
  input wire logic [3:0] memSel,
  input wire logic [31:0] memAdr,
  input wire logic [31:0] memDatW,
  output logic [31:0] memDatR,
  output logic memAck,
  output logic memErr,
  input wire logic [15:0] adIn,
  output mxb_pkg::mxb_pins_s busPins,
  output logic busClk
);
  import mxb_pkg::*;

  if (WINDOW_BASE[16:0] != 17'h00000) begin : gBaseCheck
    $error("WINDOW_BASE must be aligned to the 128 KB window");
  end

  // ==========================================================
  // Declarations
  logic [31:0] ctrl_q;
  logic [31:0] time_q;
  logic tick;
  mxb_state_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  mxb_cfg_s cfg_q;
  logic we_q;
  logic [31:0] adr_q;
  logic [31:0] wdat_q;
  logic [31:0] rdata_q;
  logic [3:0] pend_q;
  logic [3:0] pendRest;
  logic [1:0] unit_q;
  logic [1:0] unitSel;
  logic prevRead_q;
  logic memReq;
  logic hit;
  logic busEnable;
  logic [15:0] extAddr;
  logic [15:0] extWrite;
  logic addrPhase;
  logic dataPhase;
  logic [15:0] adS1_q, adS2_q, adS3_q, adStable_q;
  logic strobeEnd;
  logic holdEnd;
  logic wbAck_q;
  logic [31:0] wbDatR_q;
  logic memErr_q;

  function automatic logic [1:0] firstUnit(input logic [3:0] m);
    logic [1:0] u;
    u = 2'h3;
    if (m[2]) u = 2'h2;
    if (m[1]) u = 2'h1;
    if (m[0]) u = 2'h0;
    return u;
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r & mask;
  endfunction

  // ==========================================================
  // Register slave
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wbAck_q <= 1'b0;
    end else begin
      wbAck_q <= wbCyc & wbStb & ~wbAck_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      time_q <= TIME_RESET;
    end else if (wbCyc & wbStb & wbWe & ~wbAck_q) begin
      if (wbAdr == ADR_CTRL) begin
        ctrl_q <= mergeBytes(ctrl_q, wbDatW, wbSel, CTRL_MASK);
      end
      if (wbAdr == ADR_TIME) begin
        time_q <= mergeBytes(time_q, wbDatW, wbSel, TIME_MASK);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wbDatR_q <= 32'h0000_0000;
    end else if (wbCyc & wbStb & ~wbAck_q) begin
      case (wbAdr)
        ADR_CTRL: wbDatR_q <= ctrl_q;
        ADR_TIME: wbDatR_q <= time_q;
        ADR_STAT: begin
          wbDatR_q <= 32'h0000_0000;
          wbDatR_q[STAT_BUSY_BIT] <= (state_q != ST_IDLE);
          wbDatR_q[STAT_PREVRD_BIT] <= prevRead_q;
          wbDatR_q[STAT_PEND_LSB +: 4] <= pend_q;
        end
        default: wbDatR_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wbAck = wbAck_q;
  assign wbDatR = wbDatR_q;

  // ==========================================================
  // Bus clock
  mxb_clk_div uDiv (
    .sys_clk(sys_clk),
    .rst(rst),
    .busClockDivider(ctrl_q[CTRL_DIV_LSB +: 3]),
    .tick(tick),
    .busClk(busClk)
  );

  // ==========================================================
  // Read data synchroniser; a bit changes once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adS1_q <= 16'h0000;
      adS2_q <= 16'h0000;
      adS3_q <= 16'h0000;
      adStable_q <= 16'h0000;
    end else begin
      adS1_q <= adIn;
      adS2_q <= adS1_q;
      adS3_q <= adS2_q;
      adStable_q <= (adS3_q & ~(adS2_q ^ adS3_q)) | (adStable_q & (adS2_q ^ adS3_q));
    end
  end

  // ==========================================================
  // Window decode
  assign memReq = memCyc & memStb;
  assign hit = (memAdr[31:17] == WINDOW_BASE[31:17]);
  assign busEnable = ctrl_q[CTRL_EN_BIT];
  assign pendRest = pend_q & ~(4'h1 << unit_q);
  assign strobeEnd = (state_q == ST_STROBE) && tick && (cnt_q == 5'h00);
  assign holdEnd = (state_q == ST_HOLD) && tick && (cnt_q == 5'h00);

  // ==========================================================
  // Access sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (memReq && hit && busEnable) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (pend_q == 4'h0) begin
            state_d = ST_FIN;
          end else if (!we_q && prevRead_q && cfg_q.readReadIdle != 4'h0) begin
            state_d = ST_GAP;
            cnt_d = {1'b0, cfg_q.readReadIdle - 4'h1};
          end else begin
            state_d = ST_SETUP;
            cnt_d = ADDR_SETUP_LAST;
          end
        end
      end
      ST_SETUP: begin
        if (tick) begin
          state_d = ST_LATCH;
          cnt_d = {2'b00, cfg_q.latchWidth};
        end
      end
      ST_LATCH: begin
        if (tick) begin
          if (cnt_q == 5'h00) begin
            state_d = ST_LHOLD;
            cnt_d = LATCH_HOLD_LAST;
          end else begin
            cnt_d = cnt_q - 5'h01;
          end
        end
      end
      ST_LHOLD: begin
        if (tick) begin
          state_d = ST_TURN;
          cnt_d = TURNAROUND_LAST;
        end
      end
      ST_TURN: begin
        if (tick) begin
          state_d = ST_STROBE;
          cnt_d = cfg_q.accessTime;
        end
      end
      ST_STROBE: begin
        if (tick) begin
          if (cnt_q == 5'h00) begin
            state_d = ST_HOLD;
            cnt_d = {2'b00, cfg_q.holdTime};
          end else begin
            cnt_d = cnt_q - 5'h01;
          end
        end
      end
      ST_HOLD: begin
        if (tick) begin
          if (cnt_q != 5'h00) begin
            cnt_d = cnt_q - 5'h01;
          end else if (we_q && cfg_q.postWriteIdle != 4'h0) begin
            state_d = ST_GAP;
            cnt_d = {1'b0, cfg_q.postWriteIdle - 4'h1};
          end else if (pendRest != 4'h0) begin
            if (!we_q && cfg_q.readReadIdle != 4'h0) begin
              state_d = ST_GAP;
              cnt_d = {1'b0, cfg_q.readReadIdle - 4'h1};
            end else begin
              state_d = ST_SETUP;
              cnt_d = ADDR_SETUP_LAST;
            end
          end else begin
            state_d = ST_FIN;
          end
        end
      end
      ST_GAP: begin
        if (tick) begin
          if (cnt_q != 5'h00) begin
            cnt_d = cnt_q - 5'h01;
          end else if (pend_q != 4'h0) begin
            state_d = ST_SETUP;
            cnt_d = ADDR_SETUP_LAST;
          end else begin
            state_d = ST_FIN;
          end
        end
      end
      ST_FIN: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Request capture; settings except the bus clock divider and enable frozen so register writes cannot tear an access
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= '0;
      we_q <= 1'b0;
      adr_q <= 32'h0000_0000;
      wdat_q <= 32'h0000_0000;
    end else if (state_q == ST_IDLE && state_d == ST_WAIT) begin
      cfg_q.wide <= ctrl_q[CTRL_WIDE_BIT];
      cfg_q.latchWidth <= ctrl_q[CTRL_ALE_LSB +: 3];
      cfg_q.accessTime <= time_q[TIME_ACC_LSB +: 5];
      cfg_q.holdTime <= time_q[TIME_AHD_LSB +: 3];
      cfg_q.postWriteIdle <= time_q[TIME_W2X_LSB +: 4];
      cfg_q.readReadIdle <= time_q[TIME_R2R_LSB +: 4];
      we_q <= memWe;
      adr_q <= memAdr;
      wdat_q <= memDatW;
    end
  end

  // Pending units: bytes in narrow width, halfwords in wide width
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q <= 4'h0;
    end else if (state_q == ST_IDLE && state_d == ST_WAIT) begin
      pend_q <= ctrl_q[CTRL_WIDE_BIT] ? {2'b00, |memSel[3:2], |memSel[1:0]} : memSel;
    end else if (holdEnd) begin
      pend_q <= pendRest;
    end
  end

  // Leaving hold, the finished unit is still in pend_q, so pick from what remains
  assign unitSel = (state_d == ST_SETUP && state_q != ST_SETUP) ?
                   firstUnit((state_q == ST_HOLD) ? pendRest : pend_q) : unit_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unit_q <= 2'h0;
    end else begin
      unit_q <= unitSel;
    end
  end

  // Read data assembly, sampled as the strobe ends
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (state_q == ST_IDLE && state_d == ST_WAIT) begin
      rdata_q <= 32'h0000_0000;
    end else if (strobeEnd && !we_q) begin
      if (cfg_q.wide) begin
        rdata_q[16*unit_q[0] +: 16] <= adStable_q;
      end else begin
        rdata_q[8*unit_q +: 8] <= adStable_q[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prevRead_q <= 1'b0;
    end else if (state_q == ST_FIN) begin
      prevRead_q <= ~we_q;
    end
  end

  // Stall the system master until every sub-access and gap is done
  assign memAck = (state_q == ST_FIN);
  assign memDatR = rdata_q;

  // Misses and disabled bus answer with an error, never a hang
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      memErr_q <= 1'b0;
    end else begin
      memErr_q <= memReq && (state_q == ST_IDLE) && !(hit && busEnable) && !memErr_q;
    end
  end
  assign memErr = memErr_q;

  // ==========================================================
  // External address and write data; bit 16 dropped narrow, bit 0 dropped wide
  always_comb begin
    if (cfg_q.wide) begin
      extAddr = {adr_q[16:2], unitSel[0]};
      extWrite = wdat_q[16*unitSel[0] +: 16];
    end else begin
      extAddr = {adr_q[15:2], unitSel};
      extWrite = {adr_q[15:8], wdat_q[8*unitSel +: 8]};
    end
  end

  assign addrPhase = (state_d == ST_SETUP) || (state_d == ST_LATCH) || (state_d == ST_LHOLD);
  assign dataPhase = (state_d == ST_TURN) || (state_d == ST_STROBE) || (state_d == ST_HOLD);

  // ==========================================================
  // Pin registers, loaded from next state so they move on the tick edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busPins.selectNOut <= 1'b1;
      busPins.addrLatch <= 1'b0;
      busPins.rdStrobeN <= 1'b1;
      busPins.wrStrobeN <= 1'b1;
      busPins.adOut <= 16'h0000;
      busPins.adOeN <= 16'hffff;
    end else begin
      busPins.selectNOut <= ~(addrPhase | dataPhase);
      busPins.addrLatch <= (state_d == ST_LATCH);
      busPins.rdStrobeN <= ~((state_d == ST_STROBE) & ~we_q);
      busPins.wrStrobeN <= ~((state_d == ST_STROBE) & we_q);
      if (addrPhase) begin
        busPins.adOut <= extAddr;
        busPins.adOeN <= 16'h0000;
      end else if (dataPhase && !cfg_q.wide) begin
        busPins.adOut <= we_q ? extWrite : {extAddr[15:8], 8'h00};
        busPins.adOeN <= we_q ? 16'h0000 : 16'h00ff;
      end else if (dataPhase) begin
        busPins.adOut <= we_q ? extWrite : 16'h0000;
        busPins.adOeN <= we_q ? 16'h0000 : 16'hffff;
      end else begin
        busPins.adOut <= 16'h0000;
        busPins.adOeN <= 16'hffff;
      end
    end
  end

endmodule // mxb_bus_ctrl
`default_nettype wire

// File: mxb_bus_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mxb_bus_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic memCyc,
  input wire logic memStb,
  input wire logic memAck,
  input wire logic memErr,
  input wire mxb_pkg::mxb_pins_s busPins
);
  import mxb_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Pin sequencing
  property p_setup;
    $rose(busPins.addrLatch) |-> $past(!busPins.selectNOut);
  endproperty
  a_setup: assert property (p_setup) else $error("latch rose without setup");
  property p_turn;
    ($fell(busPins.rdStrobeN) || $fell(busPins.wrStrobeN))
      |-> !$past(busPins.addrLatch) && !$past(busPins.addrLatch, 2);
  endproperty
  a_turn: assert property (p_turn) else $error("strobe too close to latch");
  property p_adrout;
    busPins.addrLatch |-> busPins.adOeN == 16'h0000;
  endproperty
  a_adrout: assert property (p_adrout) else $error("lines float under latch");
  property p_rdfloat;
    !busPins.rdStrobeN |-> busPins.adOeN[7:0] == 8'hff;
  endproperty
  a_rdfloat: assert property (p_rdfloat) else $error("low lines driven in read");
  property p_wrdrive;
    !busPins.wrStrobeN |-> busPins.adOeN == 16'h0000;
  endproperty
  a_wrdrive: assert property (p_wrdrive) else $error("lines float in write");
  property p_excl;
    !busPins.rdStrobeN |-> busPins.wrStrobeN;
  endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  // Control activity outside a selected access would hit a neighbour
  property p_idle;
    (!busPins.rdStrobeN || !busPins.wrStrobeN || busPins.addrLatch) |-> !busPins.selectNOut;
  endproperty
  a_idle: assert property (p_idle) else $error("control active while deselected");
  property p_hold;
    ($rose(busPins.rdStrobeN) || $rose(busPins.wrStrobeN)) |-> !busPins.selectNOut;
  endproperty
  a_hold: assert property (p_hold) else $error("select dropped with strobe");
  property p_ack;
    memAck |-> busPins.selectNOut && busPins.rdStrobeN && busPins.wrStrobeN;
  endproperty
  a_ack: assert property (p_ack) else $error("ack before access end");
  property p_err;
    memErr |-> $past(memCyc && memStb) && busPins.selectNOut;
  endproperty
  a_err: assert property (p_err) else $error("error without request");
  c_ack: cover property (memAck);
  c_err: cover property (memErr);
  c_rd: cover property ($fell(busPins.rdStrobeN));
  c_wr: cover property ($fell(busPins.wrStrobeN));
endmodule // mxb_bus_ctrl_monitor
bind mxb_bus_ctrl mxb_bus_ctrl_monitor u_mxb_bus_ctrl_monitor (.sys_clk(sys_clk), .rst(rst),
  .memCyc(memCyc), .memStb(memStb), .memAck(memAck), .memErr(memErr), .busPins(busPins));
`default_nettype wire

// File: mxb_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
module mxb_clk_div (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] busClockDivider,
  output logic tick,
  output logic busClk
);
  import mxb_pkg::*;

  logic [4:0] cnt_q;
  logic [5:0] ratio;
  logic [5:0] half;
  logic [4:0] cnt_d;

  // ==========================================================
  // Ratio decode; unknown codes fall back to divide-by-1
  always_comb begin
    ratio = (busClockDivider <= DIV_MAX_CODE) ? (DIV_ONE << busClockDivider) : DIV_ONE;
    half = ratio >> 1;
    cnt_d = ({1'b0, cnt_q} >= ratio - DIV_ONE) ? 5'h00 : cnt_q + 5'h01;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Above divide-by-1 the tick lands where the bus clock falls, so pins move on its falling edge
  assign tick = (ratio == DIV_ONE) ? 1'b1 : ({1'b0, cnt_q} == half - DIV_ONE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busClk <= 1'b1;
    end else begin
      busClk <= (ratio == DIV_ONE) ? 1'b1 : ({1'b0, cnt_d} < half);
    end
  end
endmodule // mxb_clk_div
`default_nettype wire

// File: mxb_ext_mem.sv
`timescale 1ns/100ps
`default_nettype none
module mxb_ext_mem (
  input wire logic sys_clk,
  input wire mxb_pkg::mxb_pins_s busPins,
  input wire logic [15:0] adBus,
  output logic [15:0] adDrv
);
  import mxb_pkg::*;
  logic [15:0] latchQ;
  logic [15:0] lastQ = 16'h0000;
  logic [15:0] mem [256];
  logic rdOn;
  // ==========================================================
  // Transparent address latch, open while addrLatch is high
  always_latch begin
    if (busPins.addrLatch) begin
      latchQ <= adBus;
    end
  end
  assign rdOn = !busPins.selectNOut && !busPins.rdStrobeN;
  always @(posedge sys_clk) begin
    if (!busPins.selectNOut && !busPins.wrStrobeN) begin
      mem[latchQ[7:0]] <= adBus;
    end
    if (rdOn) begin
      lastQ <= adDrv;
    end
  end
  // Released lines show the inverse, so stale data cannot pass
  assign adDrv = rdOn ? mem[latchQ[7:0]] : ~lastQ;
endmodule // mxb_ext_mem
`default_nettype wire

// File: mxb_pkg.sv
package mxb_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TIME = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TIME_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0007_0703;
  localparam logic [31:0] TIME_MASK = 32'h0f00_f7f8;

  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WIDE_BIT = 1;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_ALE_LSB = 16;
  localparam int TIME_ACC_LSB = 3;
  localparam int TIME_AHD_LSB = 8;
  localparam int TIME_W2X_LSB = 12;
  localparam int TIME_R2R_LSB = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PREVRD_BIT = 1;
  localparam int STAT_PEND_LSB = 4;

  // ==========================================================
  // Bus clock divider codes
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  localparam logic [5:0] DIV_ONE = 6'h01;

  // ==========================================================
  // Fixed phases, in bus clocks, stored as remaining-count values
  localparam logic [4:0] ADDR_SETUP_LAST = 5'h00;
  localparam logic [4:0] LATCH_HOLD_LAST = 5'h00;
  localparam logic [4:0] TURNAROUND_LAST = 5'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic wide;
    logic [2:0] latchWidth;
    logic [4:0] accessTime;
    logic [2:0] holdTime;
    logic [3:0] postWriteIdle;
    logic [3:0] readReadIdle;
  } mxb_cfg_s;

  typedef struct packed {
    logic selectNOut;
    logic addrLatch;
    logic rdStrobeN;
    logic wrStrobeN;
    logic [15:0] adOut;
    logic [15:0] adOeN;
  } mxb_pins_s;

  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_WAIT   = 10'h002,
    ST_SETUP  = 10'h004,
    ST_LATCH  = 10'h008,
    ST_LHOLD  = 10'h010,
    ST_TURN   = 10'h020,
    ST_STROBE = 10'h040,
    ST_HOLD   = 10'h080,
    ST_GAP    = 10'h100,
    ST_FIN    = 10'h200
  } mxb_state_e;

endpackage

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin nMismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import mxb_pkg::*;
  localparam logic [31:0] BASE = 32'h6000_0000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, memCyc = 1'b0, memStb = 1'b0, memWe = 1'b0;
  logic [3:0] wbSel = 4'h0, memSel = 4'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0, memAdr = 32'h0, memDatW = 32'h0, wbDatR, memDatR, q;
  logic wbAck, memAck, memErr, busClk, err, prevSel, prevClk;
  mxb_pins_s busPins;
  logic [15:0] adBus, adDrv, lastAddr;
  logic [7:0] rdHigh;
  int nMismatch = 0, totalChecks = 0, aleCnt = 0, stbCnt = 0, hCnt = 0;
  int aleLen, stbLen, holdLen, nLatch = 0, nCsRise = 0, nClk = 0, l0, c0;
  always #10 sys_clk = ~sys_clk;
  assign adBus = (~busPins.adOeN & busPins.adOut) | (busPins.adOeN & adDrv);
  mxb_bus_ctrl #(.WINDOW_BASE(BASE)) u_mxb_bus_ctrl (.sys_clk(sys_clk), .rst(rst),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .memCyc(memCyc), .memStb(memStb),
    .memWe(memWe), .memSel(memSel), .memAdr(memAdr), .memDatW(memDatW),
    .memDatR(memDatR), .memAck(memAck), .memErr(memErr), .adIn(adBus),
    .busPins(busPins), .busClk(busClk));
  mxb_ext_mem u_mxb_ext_mem (.sys_clk(sys_clk), .busPins(busPins), .adBus(adBus),
    .adDrv(adDrv));
  // ==========================================================
  // Pin timing, counted in system clocks
  always @(posedge sys_clk) begin
    prevSel <= busPins.selectNOut;
    prevClk <= busClk;
    if (busPins.addrLatch) begin
      aleCnt <= aleCnt + 1;
      lastAddr <= adBus;
    end else if (aleCnt != 0) begin
      aleLen <= aleCnt;
      aleCnt <= 0;
      nLatch <= nLatch + 1;
    end
    if (!(busPins.rdStrobeN && busPins.wrStrobeN)) begin
      stbCnt <= stbCnt + 1;
      hCnt <= 0;
      rdHigh <= adBus[15:8];
    end else begin
      if (stbCnt != 0) begin
        stbLen <= stbCnt;
        stbCnt <= 0;
      end
      if (!busPins.selectNOut) begin
        hCnt <= hCnt + 1;
      end
    end
    if (busPins.selectNOut && prevSel === 1'b0) begin
      holdLen <= hCnt;
      nCsRise <= nCsRise + 1;
    end
    if (busClk !== prevClk) begin
      nClk <= nClk + 1;
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hf;
    wbAdr <= a;
    wbDatW <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (wbAck === 1'b1) break;
    end
    if (i == 20) begin
      nMismatch++;
      stopTest();
    end
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic memXfer(input logic we, input logic [3:0] s, input logic [31:0] a,
    input logic [31:0] d);
    int i;
    memCyc <= 1'b1;
    memStb <= 1'b1;
    memWe <= we;
    memSel <= s;
    memAdr <= a;
    memDatW <= d;
    for (i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      if (memAck === 1'b1 || memErr === 1'b1) break;
    end
    if (i == 3000) begin
      nMismatch++;
      stopTest();
    end
    q = memDatR;
    err = memErr;
    memCyc <= 1'b0;
    memStb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic stopTest();
    $display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK(busClk, 1'b1)
    wbXfer(1'b0, ADR_CTRL, 32'h0);
    `CHK(q, 32'h0)
    wbXfer(1'b0, ADR_TIME, 32'h0);
    `CHK(q, 32'h0)
    memXfer(1'b0, 4'hf, BASE, 32'h0);
    `CHK(err, 1'b1)
    wbXfer(1'b1, ADR_CTRL, 32'hffff_ffff);
    wbXfer(1'b0, ADR_CTRL, 32'h0);
    `CHK(q, 32'h0007_0703)
    wbXfer(1'b1, ADR_TIME, 32'hffff_ffff);
    wbXfer(1'b0, ADR_TIME, 32'h0);
    `CHK(q, 32'h0f00_f7f8)
    wbXfer(1'b0, 8'h0c, 32'h0);
    `CHK(q, 32'h0)
    // Wide, divide by one, latch 3, access 5, hold 3
    wbXfer(1'b1, ADR_CTRL, 32'h0002_0003);
    wbXfer(1'b1, ADR_TIME, 32'h0000_0220);
    l0 = nLatch;
    memXfer(1'b1, 4'hf, BASE + 32'h100, 32'h1234_5678);
    `CHK(nLatch - l0, 2)
    `CHK(aleLen, 3)
    `CHK(stbLen, 5)
    `CHK(holdLen, 3)
    `CHK(lastAddr, 16'h0081)
    memXfer(1'b0, 4'hf, BASE + 32'h100, 32'h0);
    `CHK(q, 32'h1234_5678)
    // Narrow, write idle of three
    wbXfer(1'b1, ADR_CTRL, 32'h0002_0001);
    wbXfer(1'b1, ADR_TIME, 32'h0000_3220);
    l0 = nLatch;
    c0 = nCsRise;
    memXfer(1'b1, 4'hf, BASE + 32'h200, 32'hcafe_f00d);
    `CHK(nLatch - l0, 4)
    `CHK(nCsRise - c0, 4)
    c0 = nCsRise;
    memXfer(1'b0, 4'hf, BASE + 32'h1_0200, 32'h0);
    `CHK(q, 32'hcafe_f00d)
    `CHK(nCsRise - c0, 1)
    `CHK(lastAddr, 16'h0203)
    `CHK(rdHigh, 8'h02)
    wbXfer(1'b0, ADR_STAT, 32'h0);
    `CHK(q, 32'h0000_0002)
    wbXfer(1'b1, ADR_TIME, 32'h0200_3220);
    c0 = nCsRise;
    memXfer(1'b0, 4'hf, BASE + 32'h200, 32'h0);
    `CHK(nCsRise - c0, 4)
    l0 = nLatch;
    memXfer(1'b1, 4'h2, BASE + 32'h3f0, 32'h0000_aa00);
    `CHK(nLatch - l0, 1)
    memXfer(1'b0, 4'h2, BASE + 32'h3f0, 32'h0);
    `CHK(q[15:8], 8'haa)
    // Divide by two stretches every phase
    wbXfer(1'b1, ADR_CTRL, 32'h0002_0101);
    c0 = nClk;
    memXfer(1'b0, 4'hf, BASE + 32'h1_0200, 32'h0);
    `CHK(q, 32'hcafe_f00d)
    `CHK(aleLen, 6)
    `CHK(stbLen, 10)
    `CHK(nClk > c0, 1'b1)
    l0 = nLatch;
    memXfer(1'b0, 4'hf, BASE + 32'h2_0000, 32'h0);
    `CHK(err, 1'b1)
    `CHK(nLatch - l0, 0)
    stopTest();
  end
endmodule // tb_top
`default_nettype wire
